// ---- agen_defines.svh ----
// constants for the stack and effective address block
`ifndef AGEN_DEFINES_SVH
`define AGEN_DEFINES_SVH
`define SFR_TOP     16'h0800
`define SP_RESET    16'h0800
`define SP_IDX      4'hF
`define WORK_REG_ZERO_IDX 4'h0
`define WORD_STEP   16'h0002
`define BYTE_STEP   16'h0001
`define NEAR_BITS   13
`define LIT5_BITS   5
`define INTDIS_BITS 14
`define BRANCH_BITS 16
`endif

// ---- agen_pkg.sv ----
// types shared by the stack and effective address block
package agen_pkg;
  typedef enum logic [3:0] {
    OP_ACCESS, OP_PUSH, OP_POP, OP_CALL_PUSH, OP_EXC_PUSH,
    OP_FILE, OP_REG_WRITE, OP_LIMIT_WRITE, OP_OPERANDS, OP_LITERALS
  } op_kind_t;
  typedef enum logic [2:0] {
    M_IND, M_POST_INC, M_POST_DEC, M_PRE_INC, M_PRE_DEC,
    M_INDEXED, M_LIT_OFF, M_ABSOLUTE
  } ea_mode_t;
  typedef enum logic [1:0] {SRC2_REG, SRC2_MEM, SRC2_LIT5} src2_t;
  typedef enum logic [1:0] {SEG_GENERAL, SEG_BOOT, SEG_SECURE} code_seg_t;
  typedef enum logic [0:0] {S_IDLE, S_PUSH_HI} seq_state_t;
  typedef struct packed {
    logic [15:0][15:0] work_regs;
    seq_state_t        state;
    logic [15:0]       pend_word;
    logic              mem_valid;
    logic              mem_write;
    logic [15:0]       mem_addr;
    logic [15:0]       mem_wdata;
    logic              stack_error;
    logic              access_blocked;
    logic              operand_valid;
    logic [15:0]       operand_a;
    logic [15:0]       operand_b;
    logic [22:0]       branch_disp;
    logic [13:0]       int_disable_count;
  } core_state_t;
endpackage : agen_pkg

// ---- agen_if.sv ----
// signals between the core sequencer, the address adder and the ram guard
`timescale 1ns/1ps
`default_nettype none
interface agen_if;
  import agen_pkg::*;
  ea_mode_t    mode;
  logic [15:0] base_val;
  logic [15:0] off_val;
  logic [15:0] literal;
  logic        byte_op;
  logic [15:0] ea;
  logic [15:0] base_upd;
  logic        base_wr;
  logic [15:0] check_ea;
  code_seg_t   code_seg;
  logic        boot_en;
  logic        gen_en;
  logic [15:0] boot_lo;
  logic [15:0] boot_hi;
  logic [15:0] gen_lo;
  logic [15:0] gen_hi;
  logic        blocked;
  modport calc  (input mode, base_val, off_val, literal, byte_op,
                 output ea, base_upd, base_wr);
  modport guard (input check_ea, code_seg, boot_en, gen_en, boot_lo, boot_hi,
                 gen_lo, gen_hi, output blocked);
  modport core  (output mode, base_val, off_val, literal, byte_op, check_ea,
                 code_seg, boot_en, gen_en, boot_lo, boot_hi, gen_lo, gen_hi,
                 input ea, base_upd, base_wr, blocked);
endinterface : agen_if
`default_nettype wire

// ---- ea_calc.sv ----
// effective address adder for the indirect addressing modes
`timescale 1ns/1ps
`default_nettype none
module ea_calc
  import agen_pkg::*;
(
  agen_if.calc bus
);
  `include "agen_defines.svh"
  logic [15:0] step;
  // byte operations step by one, word operations by two
  assign step = bus.byte_op ? `BYTE_STEP : `WORD_STEP;
  // address and base update per mode
  always_comb begin
    bus.ea       = bus.base_val;
    bus.base_upd = bus.base_val;
    bus.base_wr  = 1'b0;
    case (bus.mode)
      M_IND: bus.ea = bus.base_val;
      M_POST_INC: begin
        bus.base_upd = bus.base_val + step;
        bus.base_wr  = 1'b1;
      end
      M_POST_DEC: begin
        bus.base_upd = bus.base_val - step;
        bus.base_wr  = 1'b1;
      end
      M_PRE_INC: begin
        bus.ea       = bus.base_val + step;
        bus.base_upd = bus.ea;
        bus.base_wr  = 1'b1;
      end
      M_PRE_DEC: begin
        bus.ea       = bus.base_val - step;
        bus.base_upd = bus.ea;
        bus.base_wr  = 1'b1;
      end
      M_INDEXED: bus.ea = bus.base_val + bus.off_val;
      M_LIT_OFF: bus.ea = bus.base_val + bus.literal;
      M_ABSOLUTE: bus.ea = bus.literal;
      default: bus.ea = bus.base_val;
    endcase
  end
endmodule : ea_calc
`default_nettype wire

// ---- ram_guard.sv ----
// secure ram segment gate keyed on the executing code segment
`timescale 1ns/1ps
`default_nettype none
module ram_guard
  import agen_pkg::*;
(
  agen_if.guard bus
);
  function automatic logic in_seg(input logic [15:0] a, lo, hi);
    in_seg = (a >= lo) && (a <= hi);
  endfunction : in_seg
  // gates are independent, so an overlap of both segments needs both owners
  always_comb begin
    bus.blocked = 1'b0;
    if (bus.boot_en && in_seg(bus.check_ea, bus.boot_lo, bus.boot_hi) &&
        bus.code_seg != SEG_BOOT) begin
      bus.blocked = 1'b1;
    end
    if (bus.gen_en && in_seg(bus.check_ea, bus.gen_lo, bus.gen_hi) &&
        bus.code_seg != SEG_SECURE) begin
      bus.blocked = 1'b1;
    end
  end
endmodule : ram_guard
`default_nettype wire

// ---- stack_and_ea_generation.sv ----
// stack pointer, stack limit checks and effective address sequencing
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - working register fifteen is the stack pointer, pointing at the next free word
// - pop decrements before the access, push increments after it
// - call pushes carry a zero-extended upper program counter word
// - exception pushes merge the status low byte into the upper word
// - the stack limit register has no reset value
// - the stack limit register bit zero reads zero once the register is written
// - every stack-pointer based address is compared with the limit
// - push at pointer equal to limit is fine, the next one traps
// - stack addresses below 0x0800 raise the stack error trap
// - outside stack pushes and pops, boot secure ram only serves code from the boot flash segment
// - outside stack pushes and pops, general secure ram only serves code from the secure flash segment
// - file register ops take a 13-bit near address
// - file register results go to the file register or register zero
// - the move instruction reaches the whole data space
// - first three-operand source is always a working register
// - second source is register, memory or 5-bit literal
// - register indirect uses the base register unchanged
// - post-modified uses the base then steps it
// - pre-modified steps the base then uses it
// - one shared offset register field serves source and destination
// - branch literal is 16-bit signed, interrupt disable literal 14-bit
// - indexed adds the offset register, literal offset adds a literal
module stack_and_ea_generation
  import agen_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        op_valid,
  output logic             op_ready,
  input  wire op_kind_t    op_kind,
  input  wire ea_mode_t    op_mode,
  input  wire src2_t       op_src2,
  input  wire logic [3:0]  op_base_idx,
  input  wire logic [3:0]  op_off_idx,
  input  wire logic [15:0] op_literal,
  input  wire logic [15:0] op_data,
  input  wire logic        op_byte,
  input  wire logic        op_write,
  input  wire logic        op_to_default_working_register,
  input  wire logic [22:0] pc_value,
  input  wire logic [7:0]  status_low_byte,
  input  wire code_seg_t   code_segment,
  input  wire logic        boot_secure_ram_en,
  input  wire logic        general_secure_ram_en,
  input  wire logic [15:0] boot_secure_ram_lo,
  input  wire logic [15:0] boot_secure_ram_hi,
  input  wire logic [15:0] general_secure_ram_lo,
  input  wire logic [15:0] general_secure_ram_hi,
  output logic             mem_valid_r,
  output logic             mem_write_r,
  output logic [15:0]      mem_addr_r,
  output logic [15:0]      mem_wdata_r,
  output logic             stack_error_r,
  output logic             access_blocked_r,
  output logic             operand_valid_r,
  output logic [15:0]      operand_a_r,
  output logic [15:0]      operand_b_r,
  output logic [22:0]      branch_disp_r,
  output logic [13:0]      int_disable_count_r,
  output logic [15:0]      stack_pointer_register,
  output logic [15:0]      stack_limit_register
);
  `include "agen_defines.svh"

  //------------------------------------------------------------
  // state and helpers
  //------------------------------------------------------------
  core_state_t st_r;
  core_state_t st_nxt;
  logic [15:0] stack_limit_r;
  logic [15:0] sp;
  logic [15:0] near_ea;
  logic        take;
  agen_if      bus ();

  function automatic logic stack_fault(input logic [15:0] a, lim);
    stack_fault = (a > lim) || (a < `SFR_TOP);
  endfunction : stack_fault

  assign sp       = st_r.work_regs[`SP_IDX];
  assign op_ready = (st_r.state == S_IDLE);
  assign take     = op_valid && op_ready;
  assign near_ea  = {{(16 - `NEAR_BITS){1'b0}}, op_literal[`NEAR_BITS-1:0]};

  //------------------------------------------------------------
  // address adder and guard
  //------------------------------------------------------------
  // one offset index for both ends of a move
  assign bus.mode     = op_mode;
  assign bus.base_val = st_r.work_regs[op_base_idx];
  assign bus.off_val  = st_r.work_regs[op_off_idx];
  assign bus.literal  = op_literal;
  assign bus.byte_op  = op_byte;
  assign bus.check_ea = (op_kind == OP_FILE) ? near_ea : bus.ea;
  assign bus.code_seg = code_segment;
  assign bus.boot_en  = boot_secure_ram_en;
  assign bus.gen_en   = general_secure_ram_en;
  assign bus.boot_lo  = boot_secure_ram_lo;
  assign bus.boot_hi  = boot_secure_ram_hi;
  assign bus.gen_lo   = general_secure_ram_lo;
  assign bus.gen_hi   = general_secure_ram_hi;

  ea_calc u_ea_calc (
    .bus (bus.calc)
  );

  ram_guard u_ram_guard (
    .bus (bus.guard)
  );

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  // one request per idle cycle; call and exception pushes take two unless the first word traps
  always_comb begin
    st_nxt                = st_r;
    st_nxt.mem_valid      = 1'b0;
    st_nxt.mem_write      = 1'b0;
    st_nxt.stack_error    = 1'b0;
    st_nxt.access_blocked = 1'b0;
    st_nxt.operand_valid  = 1'b0;
    case (st_r.state)
      S_IDLE: begin
        if (take) begin
          case (op_kind)
            OP_PUSH, OP_CALL_PUSH, OP_EXC_PUSH: begin
              // trap on the push past the limit
              if (stack_fault(sp, stack_limit_r)) begin
                st_nxt.stack_error = 1'b1;
              end else begin
                st_nxt.mem_valid = 1'b1;
                st_nxt.mem_write = 1'b1;
                st_nxt.mem_addr  = sp;
                st_nxt.mem_wdata = (op_kind == OP_PUSH) ? op_data : pc_value[15:0];
                st_nxt.work_regs[`SP_IDX] = sp + `WORD_STEP;
                if (op_kind != OP_PUSH) begin
                  st_nxt.state = S_PUSH_HI;
                end
              end
              st_nxt.pend_word = {9'h000, pc_value[22:16]};
              if (op_kind == OP_EXC_PUSH) begin
                st_nxt.pend_word = {status_low_byte, 1'b0, pc_value[22:16]};
              end
            end
            OP_POP: begin
              // floor checked on the decremented pointer
              if (stack_fault(sp - `WORD_STEP, stack_limit_r)) begin
                st_nxt.stack_error = 1'b1;
              end else begin
                st_nxt.work_regs[`SP_IDX] = sp - `WORD_STEP;
                st_nxt.mem_valid = 1'b1;
                st_nxt.mem_addr  = sp - `WORD_STEP;
              end
            end
            OP_ACCESS, OP_OPERANDS: begin
              if (op_kind == OP_OPERANDS) begin
                st_nxt.operand_a     = st_r.work_regs[op_off_idx];
                st_nxt.operand_valid = 1'b1;
                case (op_src2)
                  SRC2_REG:  st_nxt.operand_b = bus.base_val;
                  SRC2_LIT5: st_nxt.operand_b = {11'h000, op_literal[`LIT5_BITS-1:0]};
                  default:   st_nxt.operand_b = 16'h0000;
                endcase
              end
              if (op_kind == OP_ACCESS || op_src2 == SRC2_MEM) begin
                if (op_base_idx == `SP_IDX && op_mode != M_ABSOLUTE &&
                    stack_fault(bus.ea, stack_limit_r)) begin
                  st_nxt.stack_error = 1'b1;
                end else if (bus.blocked) begin
                  st_nxt.access_blocked = 1'b1;
                end else begin
                  st_nxt.mem_valid = 1'b1;
                  st_nxt.mem_write = op_write && (op_kind == OP_ACCESS);
                  st_nxt.mem_addr  = bus.ea;
                  st_nxt.mem_wdata = op_data;
                  if (bus.base_wr) begin
                    st_nxt.work_regs[op_base_idx] = bus.base_upd;
                  end
                end
              end
            end
            OP_FILE: begin
              // result to register zero or back to the file register
              if (op_to_default_working_register) begin
                st_nxt.work_regs[`WORK_REG_ZERO_IDX] = op_data;
              end else if (bus.blocked) begin
                st_nxt.access_blocked = 1'b1;
              end else begin
                st_nxt.mem_valid = 1'b1;
                st_nxt.mem_write = op_write;
                st_nxt.mem_addr  = near_ea;
                st_nxt.mem_wdata = op_data;
              end
            end
            OP_REG_WRITE: begin
              st_nxt.work_regs[op_base_idx] = op_data;
            end
            OP_LITERALS: begin
              // signed branch and unsigned disable count
              st_nxt.branch_disp = {{(23 - `BRANCH_BITS){op_literal[15]}}, op_literal};
              st_nxt.int_disable_count = op_literal[`INTDIS_BITS-1:0];
            end
            default: begin
              st_nxt.state = S_IDLE;
            end
          endcase
        end
      end
      S_PUSH_HI: begin
        st_nxt.state = S_IDLE;
        // the upper word is a push in its own right
        if (stack_fault(sp, stack_limit_r)) begin
          st_nxt.stack_error = 1'b1;
        end else begin
          st_nxt.mem_valid = 1'b1;
          st_nxt.mem_write = 1'b1;
          st_nxt.mem_addr  = sp;
          st_nxt.mem_wdata = st_r.pend_word;
          st_nxt.work_regs[`SP_IDX] = sp + `WORD_STEP;
        end
      end
      default: st_nxt.state = S_IDLE;
    endcase
  end

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.work_regs[`SP_IDX] <= `SP_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // no reset term, undefined until written
  always_ff @(posedge ref_clk) begin
    if (take && op_kind == OP_LIMIT_WRITE) begin
      stack_limit_r <= {op_data[15:1], 1'b0};
    end
  end

  assign mem_valid_r            = st_r.mem_valid;
  assign mem_write_r            = st_r.mem_write;
  assign mem_addr_r             = st_r.mem_addr;
  assign mem_wdata_r            = st_r.mem_wdata;
  assign stack_error_r          = st_r.stack_error;
  assign access_blocked_r       = st_r.access_blocked;
  assign operand_valid_r        = st_r.operand_valid;
  assign operand_a_r            = st_r.operand_a;
  assign operand_b_r            = st_r.operand_b;
  assign branch_disp_r          = st_r.branch_disp;
  assign int_disable_count_r    = st_r.int_disable_count;
  assign stack_pointer_register = sp;
  assign stack_limit_register   = stack_limit_r;

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  logic push_ok;
  assign push_ok = take && op_kind == OP_PUSH && !stack_fault(sp, stack_limit_r);

  property p_push_step;
    @(posedge ref_clk) disable iff (!resetn)
    push_ok |=> mem_write_r && mem_addr_r == $past(sp) && sp == $past(sp) + 16'h0002;
  endproperty
  a_push_step: assert property (p_push_step) else $error("push step wrong");

  property p_pop_pre;
    @(posedge ref_clk) disable iff (!resetn)
    take && op_kind == OP_POP && !stack_error_r ##1 mem_valid_r |->
      mem_addr_r == sp && sp == $past(sp) - 16'h0002;
  endproperty
  a_pop_pre: assert property (p_pop_pre) else $error("pop pre-decrement wrong");

  property p_call_zero;
    @(posedge ref_clk) disable iff (!resetn)
    take && op_kind == OP_CALL_PUSH ##1 mem_valid_r ##1 mem_valid_r |->
      mem_wdata_r[15:7] == 9'h000;
  endproperty
  a_call_zero: assert property (p_call_zero) else $error("call upper not clear");

  property p_exc_merge;
    @(posedge ref_clk) disable iff (!resetn)
    take && op_kind == OP_EXC_PUSH ##1 mem_valid_r ##1 mem_valid_r |->
      mem_wdata_r[15:8] == $past(status_low_byte, 2);
  endproperty
  a_exc_merge: assert property (p_exc_merge) else $error("status byte missing");

  property p_limit_lsb;
    @(posedge ref_clk) disable iff (!resetn)
    take && op_kind == OP_LIMIT_WRITE |=>
      stack_limit_register == {$past(op_data[15:1]), 1'b0};
  endproperty
  a_limit_lsb: assert property (p_limit_lsb) else $error("limit bit zero set");

  property p_equal_ok;
    @(posedge ref_clk) disable iff (!resetn)
    take && op_kind == OP_PUSH && sp == stack_limit_r && sp >= 16'h0800 |=>
      !stack_error_r ##0 mem_valid_r;
  endproperty
  a_equal_ok: assert property (p_equal_ok) else $error("trap at equal limit");

  property p_over_trap;
    @(posedge ref_clk) disable iff (!resetn)
    take && op_kind == OP_PUSH && sp > stack_limit_r |=>
      stack_error_r && !mem_valid_r && $stable(sp);
  endproperty
  a_over_trap: assert property (p_over_trap) else $error("overflow not trapped");

  property p_under_trap;
    @(posedge ref_clk) disable iff (!resetn)
    take && op_kind == OP_POP && sp - 16'h0002 < 16'h0800 |=>
      stack_error_r && !mem_valid_r;
  endproperty
  a_under_trap: assert property (p_under_trap) else $error("underflow not trapped");

  property p_guard;
    @(posedge ref_clk) disable iff (!resetn)
    take && bus.blocked && (op_kind == OP_FILE && !op_to_default_working_register ||
      op_kind == OP_ACCESS && op_base_idx != `SP_IDX) |=>
      access_blocked_r && !mem_valid_r;
  endproperty
  a_guard: assert property (p_guard) else $error("secure ram not blocked");

  property p_near;
    @(posedge ref_clk) disable iff (!resetn)
    take && op_kind == OP_FILE && !op_to_default_working_register && !bus.blocked |=>
      mem_valid_r && mem_addr_r[15:13] == 3'h0 && mem_addr_r[12:0] == $past(op_literal[12:0]);
  endproperty
  a_near: assert property (p_near) else $error("near address wrong");

  property p_reg_zero_dest;
    @(posedge ref_clk) disable iff (!resetn)
    take && op_kind == OP_FILE && op_to_default_working_register |=>
      st_r.work_regs[0] == $past(op_data) && !mem_valid_r;
  endproperty
  a_reg_zero_dest: assert property (p_reg_zero_dest) else $error("register zero not written");

  c_push:  cover property (@(posedge ref_clk) disable iff (!resetn) push_ok ##1 mem_valid_r);
  c_call:  cover property (@(posedge ref_clk) disable iff (!resetn)
                           take && op_kind == OP_CALL_PUSH ##2 mem_valid_r);
  c_trap:  cover property (@(posedge ref_clk) disable iff (!resetn) stack_error_r);
  c_block: cover property (@(posedge ref_clk) disable iff (!resetn) access_blocked_r);

endmodule : stack_and_ea_generation
`default_nettype wire

// ---- data_mem_model.sv ----
// data memory bus model that records every word the block writes
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        mem_valid_r,
  input  wire logic        mem_write_r,
  input  wire logic [15:0] mem_addr_r,
  input  wire logic [15:0] mem_wdata_r
);
  logic [15:0] mem [0:65535];
  // capture writes only; the block has no read data port to answer
  always @(posedge ref_clk) begin
    if (mem_valid_r && mem_write_r) begin
      mem[mem_addr_r] <= mem_wdata_r;
    end
  end
endmodule : data_mem_model
`default_nettype wire

// ---- stack_and_ea_generation_tb_top.sv ----
// self-checking bench for the stack and effective address block
`timescale 1ns/1ps
`default_nettype none
module stack_and_ea_generation_tb_top;
  import agen_pkg::*;
  typedef struct {op_kind_t k; ea_mode_t m; logic [3:0] b;
                  logic [15:0] l, d, a, s; logic mv, er;} row_t;
  logic        ref_clk = 0, resetn = 0, op_valid = 0, op_write = 0, op_byte = 0;
  logic        op_to_default_working_register = 0;
  op_kind_t    op_kind = OP_ACCESS;
  ea_mode_t    op_mode = M_IND;
  src2_t       op_src2 = SRC2_REG;
  logic [3:0]  op_base_idx = 4'h0, op_off_idx = 4'h3;
  logic [15:0] op_literal = 16'h0000, op_data = 16'h0000;
  logic [22:0] pc_value = 23'h00_0000;
  logic [7:0]  status_low_byte = 8'h00;
  code_seg_t   code_segment = SEG_GENERAL;
  logic        boot_en = 0, gen_en = 0;
  logic        op_ready, mem_valid_r, mem_write_r, stack_error_r, access_blocked_r;
  logic        operand_valid_r;
  logic [15:0] mem_addr_r, mem_wdata_r, operand_a_r, operand_b_r, sp, lim;
  logic [22:0] branch_disp_r;
  logic [13:0] int_disable_count_r;
  int          n_fail = 0, checks_done = 0, cycles = 0;
  row_t        rows[$];
  code_seg_t   segs[4] = '{SEG_GENERAL, SEG_BOOT, SEG_BOOT, SEG_SECURE};

  // secure segment bounds are tied: one window serves both segments
  stack_and_ea_generation u_dut (.ref_clk, .resetn, .op_valid, .op_ready, .op_kind,
    .op_mode, .op_src2, .op_base_idx, .op_off_idx, .op_literal, .op_data,
    .op_byte, .op_write, .op_to_default_working_register, .pc_value, .status_low_byte,
    .code_segment,
    .boot_secure_ram_en(boot_en), .general_secure_ram_en(gen_en),
    .boot_secure_ram_lo(16'h1000), .boot_secure_ram_hi(16'h10FF),
    .general_secure_ram_lo(16'h1000), .general_secure_ram_hi(16'h10FF),
    .mem_valid_r, .mem_write_r, .mem_addr_r, .mem_wdata_r, .stack_error_r,
    .access_blocked_r, .operand_valid_r, .operand_a_r, .operand_b_r, .branch_disp_r,
    .int_disable_count_r, .stack_pointer_register(sp), .stack_limit_register(lim));
  data_mem_model u_mem (.ref_clk, .mem_valid_r, .mem_write_r, .mem_addr_r, .mem_wdata_r);

  // ----------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------
  always #50 ref_clk = ~ref_clk;
  // whole run needs well under 200 cycles; ceiling leaves ample slack
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [22:0] e, input logic [22:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // an idle edge parts two requests, so valid is never dropped and raised in one step
  task automatic op(input op_kind_t k, input ea_mode_t m, input logic [3:0] b,
                    input logic [15:0] l, input logic [15:0] d);
    @(posedge ref_clk);
    #10 op_kind = k;
    op_mode = m;
    op_base_idx = b;
    op_literal = l;
    op_data = d;
    op_valid = 1;
    @(posedge ref_clk);
    #10 op_valid = 0;
  endtask : op
  task automatic add(input op_kind_t k, input ea_mode_t m, input logic [3:0] b,
                     input logic [15:0] l, d, a, s, input logic mv, er);
    rows.push_back(row_t'{k, m, b, l, d, a, s, mv, er});
  endtask : add
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    #10 chk("sp_reset", 16'h0800, sp);
    resetn = 1;
    add(OP_REG_WRITE, M_IND, 4'h2, 0, 16'h1000, 0, 16'h0800, 0, 0);
    add(OP_REG_WRITE, M_IND, 4'h3, 0, 16'h0010, 0, 16'h0800, 0, 0);
    add(OP_ACCESS, M_IND, 4'h2, 16'h0020, 0, 16'h1000, 16'h0800, 1, 0);
    add(OP_ACCESS, M_POST_INC, 4'h2, 16'h0020, 0, 16'h1000, 16'h0800, 1, 0);
    add(OP_ACCESS, M_POST_DEC, 4'h2, 16'h0020, 0, 16'h1002, 16'h0800, 1, 0);
    add(OP_ACCESS, M_PRE_INC, 4'h2, 16'h0020, 0, 16'h1002, 16'h0800, 1, 0);
    add(OP_ACCESS, M_PRE_DEC, 4'h2, 16'h0020, 0, 16'h1000, 16'h0800, 1, 0);
    add(OP_ACCESS, M_INDEXED, 4'h2, 16'h0020, 0, 16'h1010, 16'h0800, 1, 0);
    add(OP_ACCESS, M_LIT_OFF, 4'h2, 16'h0020, 0, 16'h1020, 16'h0800, 1, 0);
    add(OP_ACCESS, M_ABSOLUTE, 4'h2, 16'hF000, 0, 16'hF000, 16'h0800, 1, 0);
    // a push, never a stack read, follows the limit write
    add(OP_LIMIT_WRITE, M_IND, 4'hF, 0, 16'h0803, 0, 16'h0800, 0, 0);
    add(OP_PUSH, M_IND, 4'hF, 0, 16'h1111, 16'h0800, 16'h0802, 1, 0);
    add(OP_PUSH, M_IND, 4'hF, 0, 16'h2222, 16'h0802, 16'h0804, 1, 0);
    add(OP_PUSH, M_IND, 4'hF, 0, 16'h3333, 0, 16'h0804, 0, 1);
    add(OP_POP, M_IND, 4'hF, 0, 0, 16'h0802, 16'h0802, 1, 0);
    add(OP_POP, M_IND, 4'hF, 0, 0, 16'h0800, 16'h0800, 1, 0);
    add(OP_POP, M_IND, 4'hF, 0, 0, 0, 16'h0800, 0, 1);
    foreach (rows[i]) begin
      op(rows[i].k, rows[i].m, rows[i].b, rows[i].l, rows[i].d);
      chk("mem_valid", rows[i].mv, mem_valid_r);
      chk("stack_error", rows[i].er, stack_error_r);
      if (rows[i].mv) chk("mem_addr", rows[i].a, mem_addr_r);
      chk("stack_ptr", rows[i].s, sp);
    end
    chk("limit", 16'h0802, lim);
    chk("pushed", 16'h1111, u_mem.mem[16'h0800]);
    // call and exception frames, two words each
    op(OP_LIMIT_WRITE, M_IND, 4'hF, 0, 16'h0FFE);
    pc_value = 23'h5A_1234;
    status_low_byte = 8'hC3;
    op(OP_CALL_PUSH, M_IND, 4'hF, 0, 0);
    chk("call_lo", 16'h1234, mem_wdata_r);
    chk("busy", 1'b0, op_ready);
    @(posedge ref_clk);
    #10 chk("call_hi", 16'h005A, mem_wdata_r);
    chk("call_hi_addr", 16'h0802, mem_addr_r);
    op(OP_EXC_PUSH, M_IND, 4'hF, 0, 0);
    @(posedge ref_clk);
    #10 chk("exc_hi", 16'hC35A, mem_wdata_r);
    chk("sp_frames", 16'h0808, sp);
    // near file access, result to register zero, operands, literals
    op_write = 1;
    op(OP_FILE, M_IND, 4'h0, 16'hFFFF, 16'h00AA);
    chk("near_addr", 16'h1FFF, mem_addr_r);
    chk("near_write", 1'b1, mem_write_r);
    op_to_default_working_register = 1;
    op(OP_FILE, M_IND, 4'h0, 16'h0004, 16'h0077);
    chk("no_mem", 1'b0, mem_valid_r);
    op_to_default_working_register = 0;
    op_write = 0;
    op_off_idx = 4'h0;
    op_src2 = SRC2_LIT5;
    op(OP_OPERANDS, M_IND, 4'h2, 16'hFFFF, 0);
    chk("operand_a", 16'h0077, operand_a_r);
    chk("operand_b_lit", 16'h001F, operand_b_r);
    chk("operand_valid", 1'b1, operand_valid_r);
    op_src2 = SRC2_REG;
    op(OP_OPERANDS, M_IND, 4'h3, 0, 0);
    chk("operand_b_reg", 16'h0010, operand_b_r);
    op(OP_LITERALS, M_IND, 4'h0, 16'hC005, 0);
    chk("branch", 23'h7F_C005, branch_disp_r);
    chk("int_dis", 14'h0005, int_disable_count_r);
    // byte operations step the base by one
    op_byte = 1;
    op(OP_ACCESS, M_PRE_INC, 4'h2, 0, 0);
    chk("byte_pre_inc", 16'h1001, mem_addr_r);
    op(OP_ACCESS, M_POST_DEC, 4'h2, 0, 0);
    chk("byte_post_dec", 16'h1001, mem_addr_r);
    op_byte = 0;
    // secure windows: wrong segment refused, owning segment served
    op_off_idx = 4'h3;
    for (int i = 0; i < 4; i++) begin
      boot_en = (i < 2);
      gen_en = (i >= 2);
      code_segment = segs[i];
      op(OP_ACCESS, M_IND, 4'h2, 0, 0);
      chk("blocked", (i % 2 == 0), access_blocked_r);
      chk("served", (i % 2 == 1), mem_valid_r);
    end
    // mid-run reset: pointer back to its reset value, limit keeps its content
    resetn = 0;
    @(posedge ref_clk);
    #10 chk("sp_rst_mid", 16'h0800, sp);
    chk("lim_kept", 16'h0FFE, lim);
    resetn = 1;
    op(OP_PUSH, M_IND, 4'hF, 0, 16'h4444);
    chk("push_after_rst", 16'h0800, mem_addr_r);
    chk("push_write", 1'b1, mem_write_r);
    stop_test();
  end
endmodule : stack_and_ea_generation_tb_top
`default_nettype wire
